// ---- hdl/sas_pkg.sv ----
package sas_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_STATUS_CONTROL = 10'h057;
    localparam logic [9:0] IDX_CLOCK_CONTROL  = 10'h058;
    localparam logic [9:0] IDX_RESULT_HIGH    = 10'h059;
    localparam logic [9:0] IDX_RESULT_LOW0    = 10'h05a;
    localparam logic [9:0] IDX_SCAN_RESULT1   = 10'h05b;
    localparam logic [9:0] IDX_SCAN_RESULT2   = 10'h05c;
    localparam logic [9:0] IDX_SCAN_RESULT3   = 10'h05d;
    localparam logic [9:0] IDX_SCAN_CONTROL   = 10'h05e;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SC_DONE_BIT   = 7;
    localparam int SC_IRQ_BIT    = 6;
    localparam int SC_CONT_BIT   = 5;
    localparam int SC_CHAN_LSB   = 0;
    localparam int CC_DIV_LSB    = 5;
    localparam int CC_SRC_BIT    = 4;
    localparam int CC_MODE_LSB   = 2;
    localparam int SCN_LAST_LSB  = 1;
    localparam int SCN_EN_BIT    = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] RST_CHANNEL_SELECT = 5'h1f;
    localparam logic [2:0] RST_DIVIDER_SELECT = 3'h0;
    localparam logic [1:0] RST_RESULT_FORMAT  = 2'h1;
    localparam logic [7:0] RST_RESULT         = 8'h00;

    // ------------------------------------------------------------
    // Timing counts, in converter clock ticks
    // ------------------------------------------------------------
    localparam logic [4:0] CONV_TICKS_MIN = 5'h10;
    localparam logic [4:0] CONV_TICKS_MAX = 5'h11;

    // ------------------------------------------------------------
    // Bus answers and result codes
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [9:0] CODE_FULL   = 10'h3ff;
    localparam logic [9:0] CODE_ZERO   = 10'h000;

    // Result formats
    typedef enum logic [1:0] {
        SAS_FMT_TRUNC8,
        SAS_FMT_RIGHT,
        SAS_FMT_LEFT,
        SAS_FMT_LEFT_SIGN
    } sas_fmt_e;

    // Divider state
    typedef struct packed {
        logic [3:0] count;
        logic       tick;
    } sas_div_s;

    // Sequencer and bus state
    typedef struct packed {
        logic            aw_held;
        logic [9:0]      aw_idx;
        logic            w_held;
        logic [7:0]      w_data;
        logic            w_lane0;
        logic            aw_rdy;
        logic            w_rdy;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            ar_rdy;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [7:0]      rdata;
        logic            irq_en;
        logic            cont_en;
        logic [4:0]      chan_sel;
        logic [2:0]      div_sel;
        logic            src_sel;
        logic [1:0]      fmt;
        logic [1:0]      scan_last;
        logic            scan_en;
        logic [7:0]      res_high;
        logic [3:0][7:0] res_low;
        logic            done;
        logic            irq;
        logic            lock;
        logic            busy;
        logic            pending;
        logic [1:0]      scan_cnt;
        logic [4:0]      ticks;
        logic            core_start;
        logic            core_clk_en;
        logic [2:0]      core_chan;
        logic [7:0]      pin_oe;
        logic [7:0]      pin_out;
        logic [7:0]      port_rd;
    } sas_state_s;

endpackage

// ---- hdl/sas_clk_div.sv ----
`timescale 1ns/1ps

module sas_clk_div
    import sas_pkg::*;
#(
    parameter int DIV_W = 4
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       src_tick,
    input  wire logic [2:0] div_sel,
    output logic            tick
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DIV_W != 4) begin : g_bad_width
        $error("sas_clk_div: DIV_W must be 4");
    end

    sas_div_s state;
    sas_div_s next_state;
    logic [3:0] limit;

    // Terminal count per ratio: 1, 2, 4, 8, else 16
    always_comb begin
        case (div_sel)
            3'h0:    limit = 4'h0;
            3'h1:    limit = 4'h1;
            3'h2:    limit = 4'h3;
            3'h3:    limit = 4'h7;
            default: limit = 4'hf;
        endcase
    end

    // Count source ticks, emit one pulse per divided period
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (src_tick) begin
            if (state.count >= limit) begin
                next_state.count = 4'h0;
                next_state.tick = 1'b1;
            end else begin
                next_state.count = state.count + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule // sas_clk_div

// ---- hdl/sas_top.sv ----
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

// What this block does
// - Mux one of eight channels, 10-bit result
// - Store result, then flag or interrupt
// - Channel select picks channel outside scan
// - Selected pin forced to converter input
// - Port read: pin if input, latch otherwise
// - Out-of-range inputs saturate to 3ff/000
// - Status write starts conversion, 16-17 ticks
// - Converter clock source and divider selectable
// - Partial first tick counted as 17th
// - Continuous mode reconverts, overwriting results
// - Done flag set; cleared by write/read
// - Scan counter picks channel and register
// - Scan start resets counter to zero
// - Each scan step stores, flags, increments unless it is the last
// - Last scan channel ends the sequence
// - Scan channels 1-3 use own registers
// - Interrupt request per conversion, cleared by access
// - High read freezes low outside 8-bit format, drops results
// - Single mode: one conversion per start
// - Stop mode aborts, resumes afterwards
module sas_top
    import sas_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              CLOCK,
    input  wire logic              RST,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    input  wire logic              OSC_TICK,
    input  wire logic              STOP_MODE,
    output logic                   CORE_START,
    output logic                   CORE_CLK_EN,
    output logic [2:0]             CORE_CHANNEL,
    input  wire logic [9:0]        CORE_RESULT,
    input  wire logic              CORE_DONE,
    input  wire logic              CORE_ABOVE_HIGH,
    input  wire logic              CORE_BELOW_LOW,
    input  wire logic [7:0]        PIN_IN,
    input  wire logic [7:0]        PORT_DATA,
    input  wire logic [7:0]        PORT_DIR,
    output logic [7:0]             PIN_OUT,
    output logic [7:0]             PIN_OE,
    output logic [7:0]             PORT_READ,
    output logic                   CONV_IRQ,
    output logic                   CONV_DONE
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
        $error("sas_top: ADDR_W must be 12 to 32");
    end

    sas_state_s state;
    sas_state_s next_state;
    logic       conv_tick;

    // ------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------
    // source and divider
    sas_clk_div #(
        .DIV_W (4)
    ) u_div (
        .clk      (CLOCK),
        .rst      (RST),
        .src_tick (state.src_sel ? OSC_TICK : 1'b1),
        .div_sel  (state.div_sel),
        .tick     (conv_tick)
    );

    // ------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------
    function automatic logic [15:0] fmt_result(input logic [1:0] fmt, input logic [9:0] r);
        case (sas_fmt_e'(fmt))
            SAS_FMT_TRUNC8:    fmt_result = {8'h00, r[9:2]};
            SAS_FMT_RIGHT:     fmt_result = {6'h00, r};
            SAS_FMT_LEFT:      fmt_result = {r, 6'h00};
            SAS_FMT_LEFT_SIGN: fmt_result = {~r[9], r[8:0], 6'h00};
            default:           fmt_result = {8'h00, r[9:2]};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic            do_write;
        logic            do_read;
        logic [9:0]      ar_idx;
        logic [9:0]      res;
        logic [15:0]     f;
        logic [2:0]      chan;
        logic            chan_ok;
        logic            complete;
        logic            stat_wr;
        logic            low0_rd;
        logic            start;
        logic [7:0]      sel_pin;
        do_write = 1'b0;
        do_read = 1'b0;
        ar_idx = S_AXI_ARADDR[11:2];
        res = CORE_RESULT;
        f = '0;
        chan = '0;
        chan_ok = 1'b0;
        complete = 1'b0;
        stat_wr = 1'b0;
        low0_rd = 1'b0;
        start = 1'b0;
        sel_pin = '0;
        next_state = state;
        next_state.core_start = 1'b0;

        // Write address and data taken in either order
        if (S_AXI_AWVALID && state.aw_rdy) begin
            next_state.aw_held = 1'b1;
            next_state.aw_idx = S_AXI_AWADDR[11:2];
        end
        if (S_AXI_WVALID && state.w_rdy) begin
            next_state.w_held = 1'b1;
            next_state.w_data = S_AXI_WDATA[7:0];
            next_state.w_lane0 = S_AXI_WSTRB[0];
        end
        if (state.bvalid && S_AXI_BREADY) begin
            next_state.bvalid = 1'b0;
        end
        if (state.aw_held && state.w_held && !state.bvalid) begin
            do_write = 1'b1;
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = (state.aw_idx >= IDX_STATUS_CONTROL &&
                                state.aw_idx <= IDX_SCAN_CONTROL) ? RESP_OKAY : RESP_SLVERR;
        end
        next_state.aw_rdy = !next_state.aw_held && !next_state.bvalid;
        next_state.w_rdy = !next_state.w_held && !next_state.bvalid;

        // Register writes, low byte lane only
        if (do_write && state.w_lane0) begin
            case (state.aw_idx)
                IDX_STATUS_CONTROL: begin
                    stat_wr = 1'b1;
                    next_state.irq_en = state.w_data[SC_IRQ_BIT];
                    next_state.cont_en = state.w_data[SC_CONT_BIT];
                    next_state.chan_sel = state.w_data[SC_CHAN_LSB +: 5];
                end
                IDX_CLOCK_CONTROL: begin
                    next_state.div_sel = state.w_data[CC_DIV_LSB +: 3];
                    next_state.src_sel = state.w_data[CC_SRC_BIT];
                    next_state.fmt = state.w_data[CC_MODE_LSB +: 2];
                    next_state.lock = 1'b0;
                end
                IDX_SCAN_CONTROL: begin
                    next_state.scan_last = state.w_data[SCN_LAST_LSB +: 2];
                    next_state.scan_en = state.w_data[SCN_EN_BIT];
                end
                default: begin
                end
            endcase
        end

        // Read channel with side effects at acceptance
        if (state.rvalid && S_AXI_RREADY) begin
            next_state.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && state.ar_rdy) begin
            do_read = 1'b1;
            next_state.rvalid = 1'b1;
            next_state.rresp = RESP_OKAY;
            case (ar_idx)
                IDX_STATUS_CONTROL: next_state.rdata = {state.done && !state.irq_en,
                                                        state.irq_en, state.cont_en,
                                                        state.chan_sel};
                IDX_CLOCK_CONTROL:  next_state.rdata = {state.div_sel, state.src_sel,
                                                        state.fmt, 2'h0};
                IDX_RESULT_HIGH:    next_state.rdata = state.res_high;
                IDX_RESULT_LOW0:    next_state.rdata = state.res_low[0];
                IDX_SCAN_RESULT1:   next_state.rdata = state.res_low[1];
                IDX_SCAN_RESULT2:   next_state.rdata = state.res_low[2];
                IDX_SCAN_RESULT3:   next_state.rdata = state.res_low[3];
                IDX_SCAN_CONTROL:   next_state.rdata = {5'h00, state.scan_last, state.scan_en};
                default: begin
                    next_state.rdata = 8'h00;
                    next_state.rresp = RESP_SLVERR;
                end
            endcase
            if (ar_idx == IDX_RESULT_HIGH && state.fmt != SAS_FMT_TRUNC8) begin
                next_state.lock = 1'b1;
            end
            low0_rd = (ar_idx == IDX_RESULT_LOW0);
        end
        next_state.ar_rdy = !next_state.rvalid;

        // low read or control write unfreezes
        if (low0_rd || stat_wr) begin
            next_state.lock = 1'b0;
        end

        if (stat_wr || low0_rd) begin
            next_state.done = 1'b0;
            next_state.irq = 1'b0;
        end

        if (state.busy && conv_tick && state.ticks != CONV_TICKS_MAX) begin
            next_state.ticks = state.ticks + 5'h01;
        end

        // done strobe taken after minimum ticks
        complete = state.busy && CORE_DONE && !STOP_MODE && state.ticks >= CONV_TICKS_MIN;
        if (complete) begin
            if (CORE_ABOVE_HIGH) begin
                res = CODE_FULL;
            end else if (CORE_BELOW_LOW) begin
                res = CODE_ZERO;
            end
            f = fmt_result(state.fmt, res);
            next_state.busy = 1'b0;
            if (!state.lock) begin
                if (state.scan_en && state.scan_cnt != 2'h0) begin
                    // scan channels 1-3 keep 8 bits
                    next_state.res_low[state.scan_cnt] = res[9:2];
                end else begin
                    next_state.res_high = f[15:8];
                    next_state.res_low[0] = f[7:0];
                end
            end
            if (state.irq_en) begin
                next_state.irq = 1'b1;
            end else begin
                next_state.done = 1'b1;
            end
            if (state.scan_en) begin
                if (state.scan_cnt != state.scan_last) begin
                    next_state.scan_cnt = state.scan_cnt + 2'h1;
                    start = 1'b1;
                end
            end else if (state.cont_en) begin
                start = 1'b1;
            end
        end

        if (stat_wr) begin
            start = 1'b1;
            next_state.scan_cnt = 2'h0;
        end

        if (STOP_MODE) begin
            if (state.busy || start) begin
                next_state.pending = 1'b1;
            end
            next_state.busy = 1'b0;
            start = 1'b0;
        end else if (state.pending) begin
            next_state.pending = 1'b0;
            start = 1'b1;
        end

        if (next_state.scan_en) begin
            chan = {1'b0, next_state.scan_cnt};
            chan_ok = 1'b1;
        end else begin
            chan = next_state.chan_sel[2:0];
            chan_ok = next_state.chan_sel[4:3] == 2'h0;
        end

        if (start && chan_ok) begin
            next_state.busy = 1'b1;
            next_state.ticks = 5'h00;
            next_state.core_start = 1'b1;
            next_state.core_chan = chan;
        end else if (start) begin
            next_state.busy = 1'b0;
        end
        next_state.core_clk_en = conv_tick && state.busy;

        sel_pin = chan_ok ? (8'h01 << chan) : 8'h00;
        next_state.pin_oe = PORT_DIR & ~sel_pin;
        next_state.pin_out = PORT_DATA;
        // pin level if input, latch if output
        next_state.port_rd = (PORT_DIR & PORT_DATA) | (~PORT_DIR & PIN_IN);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= '0;
            state.aw_rdy <= 1'b1;
            state.w_rdy <= 1'b1;
            state.ar_rdy <= 1'b1;
            state.chan_sel <= RST_CHANNEL_SELECT;
            state.div_sel <= RST_DIVIDER_SELECT;
            state.fmt <= RST_RESULT_FORMAT;
            state.res_high <= RST_RESULT;
            state.res_low <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign S_AXI_AWREADY = state.aw_rdy;
    assign S_AXI_WREADY = state.w_rdy;
    assign S_AXI_BVALID = state.bvalid;
    assign S_AXI_BRESP = state.bresp;
    assign S_AXI_ARREADY = state.ar_rdy;
    assign S_AXI_RVALID = state.rvalid;
    assign S_AXI_RRESP = state.rresp;
    assign S_AXI_RDATA = {24'h000000, state.rdata};
    assign CORE_START = state.core_start;
    assign CORE_CLK_EN = state.core_clk_en;
    assign CORE_CHANNEL = state.core_chan;
    assign PIN_OUT = state.pin_out;
    assign PIN_OE = state.pin_oe;
    assign PORT_READ = state.port_rd;
    assign CONV_IRQ = state.irq;
    assign CONV_DONE = state.done;

endmodule // sas_top

// ---- verification/sas_top_asserts.sv ----
`timescale 1ns/1ps
// --------------------
// Port checker
// --------------------
module sas_top_asserts
    import sas_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              CLOCK,
    input wire logic              RST,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic              STOP_MODE,
    input wire logic              CORE_START,
    input wire logic [2:0]        CORE_CHANNEL,
    input wire logic              CORE_DONE,
    input wire logic [7:0]        PIN_IN,
    input wire logic [7:0]        PORT_DATA,
    input wire logic [7:0]        PORT_DIR,
    input wire logic [7:0]        PIN_OE,
    input wire logic [7:0]        PORT_READ,
    input wire logic              CONV_IRQ,
    input wire logic              CONV_DONE
);
    logic [4:0] cyc;
    logic       rd_low0;
    // Cycles since the last start pulse
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cyc <= 5'h00;
        end else if (CORE_START) begin
            cyc <= 5'h01;
        end else if (cyc != 5'h1f) begin
            cyc <= cyc + 5'h01;
        end
    end
    // Read of the low result register taken
    assign rd_low0 = S_AXI_ARVALID && S_AXI_ARREADY
        && (S_AXI_ARADDR[11:2] == IDX_RESULT_LOW0);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_start_pulse: assert property (CORE_START |=> !CORE_START)
        else $error("start pulse too long");
    a_chan_hold: assert property ($changed(CORE_CHANNEL) |-> CORE_START)
        else $error("channel moved without start");
    a_pin_masked: assert property ((PIN_OE & ~$past(PORT_DIR)) == 8'h00)
        else $error("pin driven while input");
    a_port_read: assert property (!$past(RST) |-> PORT_READ ==
        (($past(PORT_DIR) & $past(PORT_DATA)) | (~$past(PORT_DIR) & $past(PIN_IN))))
        else $error("port read wrong");
    a_done_cause: assert property ($rose(CONV_DONE || CONV_IRQ) |-> $past(CORE_DONE))
        else $error("flag without core answer");
    a_low0_clear: assert property (rd_low0 && !CORE_DONE |=> !CONV_DONE && !CONV_IRQ)
        else $error("flag not cleared by read");
    a_min_ticks: assert property ($rose(CONV_DONE || CONV_IRQ) |-> cyc >= 5'h0f)
        else $error("conversion too short");
    a_stop_idle: assert property (STOP_MODE && $past(STOP_MODE) |-> !CORE_START)
        else $error("start during stop");
endmodule // sas_top_asserts

// ---- verification/sas_core_model.sv ----
`timescale 1ns/1ps
// --------------------
// Analog core stand-in
// --------------------
module sas_core_model #(
    parameter logic [4:0] LAST_TICK = 5'h10
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       clk_en,
    input  wire logic [2:0] chan,
    input  wire logic       sat_hi,
    input  wire logic       sat_lo,
    output logic [9:0]      result,
    output logic            done,
    output logic            above,
    output logic            below
);
    logic       run;
    logic [4:0] ticks;
    always @(posedge clk) begin
        done <= 1'b0;
        above <= 1'b0;
        below <= 1'b0;
        result <= rst ? 10'h155 : ~result;
        if (rst || start) begin
            run <= !rst;
            ticks <= 5'h00;
        end else if (run && clk_en) begin
            ticks <= ticks + 5'h01;
            if (ticks == LAST_TICK) begin
                run <= 1'b0;
                done <= 1'b1;
                result <= {chan, 7'h5a};
                above <= sat_hi;
                below <= sat_lo;
            end
        end
    end
endmodule // sas_core_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import sas_pkg::*;
;
    logic        clk, rst, awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy;
    logic        osc, stop, c_st, c_en, c_dn, c_hi, c_lo, s_hi, s_lo, irq, dn;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0]  br, rr;
    logic [2:0]  c_ch;
    logic [9:0]  c_res;
    logic [7:0]  pin, pd, pdir, pout, poe, prd;
    int          error_cnt, num_checks, ends, starts, s0;
    sas_top dut_u (.CLOCK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .OSC_TICK(osc),
        .STOP_MODE(stop), .CORE_START(c_st), .CORE_CLK_EN(c_en), .CORE_CHANNEL(c_ch),
        .CORE_RESULT(c_res), .CORE_DONE(c_dn), .CORE_ABOVE_HIGH(c_hi), .CORE_BELOW_LOW(c_lo),
        .PIN_IN(pin), .PORT_DATA(pd), .PORT_DIR(pdir), .PIN_OUT(pout), .PIN_OE(poe),
        .PORT_READ(prd), .CONV_IRQ(irq), .CONV_DONE(dn));
    sas_core_model core_u (.clk(clk), .rst(rst), .start(c_st), .clk_en(c_en), .chan(c_ch),
        .sat_hi(s_hi), .sat_lo(s_lo), .result(c_res), .done(c_dn), .above(c_hi), .below(c_lo));
    // Clock, oscillator ticks and event counts
    always #25 clk = ~clk;
    always @(posedge clk) begin
        osc <= ~osc;
        starts <= starts + int'(c_st);
        ends <= ends + int'(c_dn);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic hang(input int i);
        if (i >= 400) begin
            error_cnt++;
            $display("ERROR %0t: wait timed out", $time);
            final_report();
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        int i;
        @(posedge clk);
        {awa, wd} <= {idx, 2'b00, 24'h0, d};
        {awv, wv, brdy} <= 3'b111;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        hang(i);
        brdy <= 1'b0;
        chk(br, RESP_OKAY);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
        int i;
        @(posedge clk);
        ara <= {idx, 2'b00};
        {arv, rrdy} <= 2'b11;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        hang(i);
        rrdy <= 1'b0;
        chk(rdat, exp);
        chk(rr, er);
    endtask
    task automatic wait_ends(input int n);
        int i;
        for (i = 0; i < 400 && ends < n; i++) @(posedge clk);
        hang(i);
        repeat (2) @(posedge clk);
    endtask
    // Main sequence
    initial begin
        {clk, rst, awv, wv, brdy, arv, rrdy, osc, stop, s_hi, s_lo} = 11'h001 << 9;
        {awa, ara, wd, pin, pd, pdir} = {56'h0, 8'h3c, 8'ha5, 8'hff};
        {error_cnt, num_checks, ends, starts} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_STATUS_CONTROL, 32'h1f, RESP_OKAY);
        rd(IDX_CLOCK_CONTROL, 32'h04, RESP_OKAY);
        rd(IDX_SCAN_CONTROL, 32'h00, RESP_OKAY);
        rd(10'h000, 32'h00, RESP_SLVERR);
        $display("reset test done");
        wr(IDX_CLOCK_CONTROL, 8'h30);
        wr(IDX_STATUS_CONTROL, 8'h03);
        wait_ends(ends + 1);
        chk(c_ch, 3'h3);
        rd(IDX_STATUS_CONTROL, 32'h83, RESP_OKAY);
        rd(IDX_RESULT_LOW0, 32'h76, RESP_OKAY);
        rd(IDX_STATUS_CONTROL, 32'h03, RESP_OKAY);
        chk(starts, 1);
        chk(poe, 8'hf7);
        chk(pout, 8'ha5);
        pdir <= 8'h0f;
        repeat (2) @(posedge clk);
        chk(prd, 8'h35);
        $display("single test done");
        for (int k = 0; k < 2; k++) begin
            wr(IDX_CLOCK_CONTROL, k ? 8'h0c : 8'h04);
            {s_hi, s_lo} <= k ? 2'b01 : 2'b10;
            wr(IDX_STATUS_CONTROL, 8'h03);
            wait_ends(ends + 1);
            rd(IDX_RESULT_HIGH, k ? 32'h80 : 32'h03, RESP_OKAY);
            rd(IDX_RESULT_LOW0, k ? 32'h00 : 32'hff, RESP_OKAY);
        end
        {s_hi, s_lo} <= 2'b00;
        wr(IDX_STATUS_CONTROL, 8'h43);
        wait_ends(ends + 1);
        chk(irq, 1'b1);
        rd(IDX_STATUS_CONTROL, 32'h43, RESP_OKAY);
        rd(IDX_RESULT_LOW0, 32'h80, RESP_OKAY);
        chk(irq, 1'b0);
        $display("format test done");
        wr(IDX_CLOCK_CONTROL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(IDX_SCAN_CONTROL, k ? 8'h03 : 8'h07);
            s0 = starts;
            wr(IDX_STATUS_CONTROL, 8'h00);
            wait_ends(ends + (k ? 2 : 4));
            repeat (60) @(posedge clk);
            chk(starts - s0, k ? 2 : 4);
            for (int c = 0; c < (k ? 2 : 4); c++) begin
                rd(IDX_RESULT_LOW0 + 10'(c), {24'h0, c[2:0], 5'h16}, RESP_OKAY);
            end
        end
        wr(IDX_SCAN_CONTROL, 8'h00);
        $display("scan test done");
        wr(IDX_STATUS_CONTROL, 8'h23);
        wait_ends(ends + 3);
        wr(IDX_STATUS_CONTROL, 8'h03);
        wait_ends(ends + 1);
        s0 = starts;
        repeat (60) @(posedge clk);
        chk(starts, s0);
        wr(IDX_STATUS_CONTROL, 8'h03);
        stop <= 1'b1;
        repeat (100) @(posedge clk);
        chk(dn, 1'b0);
        stop <= 1'b0;
        wait_ends(ends + 1);
        chk(dn, 1'b1);
        $display("mode test done");
        final_report();
    end
endmodule // tb_top
bind sas_top sas_top_asserts #(.ADDR_W(ADDR_W)) chk_u (.CLOCK, .RST, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .STOP_MODE, .CORE_START, .CORE_CHANNEL, .CORE_DONE,
    .PIN_IN, .PORT_DATA, .PORT_DIR, .PIN_OE, .PORT_READ, .CONV_IRQ, .CONV_DONE);
